// ---- logic/utic_pkg.sv ----
// Constants for the USB/timer interrupt controller of a small 8-bit core.
// Assumes the core's data memory bus reaches the control register at its offset.
//
// Overview of operation
// - Bit 0 global enable gates all service
// - Bits 1..3 enable USB, timer0, timer1
// - Bits 4..6 hold USB, timer0, timer1 pending
// - Bit 7 unimplemented, reads zero
// - Taking interrupt clears global enable and its own pending flag
// - Nesting only after software re-enables
// - Full stack withholds acknowledge until level drops
// - Only program counter pushed on entry
// - Four USB events set USB pending
// - USB service calls 04H, clears flag, enable
// - Timer0 overflow pends; service calls 08H
// - Timer1 overflow pends; service calls 0CH
// - FIFO access sets endpoint status bit
// - Suspend sets status bit 0, raises USB
// - Resume sets status bit 3, raises USB
// - Bus reset raises USB request
// - Requests sampled and serviced on phase two
// - Fixed priority USB, timer0, timer1
// - Interrupt return sets global enable; plain return not
// - Other acknowledges held until re-enabled or interrupt return
// - Pending stays until serviced or cleared
// - Every source can wake from power-down
// - Stack holds eight; full gates acknowledge
package utic_pkg;
    localparam logic [7:0] UTIC_INTERRUPT_CONTROL_REG_ADDR   = 8'h0B;
    localparam logic [7:0] UTIC_USC_ADDR    = 8'h1A;
    localparam logic [7:0] UTIC_USR_ADDR    = 8'h1B;
    localparam int         UTIC_BIT_GEN     = 0;
    localparam int         UTIC_BIT_EN_USB  = 1;
    localparam int         UTIC_BIT_EN_T0   = 2;
    localparam int         UTIC_BIT_EN_T1   = 3;
    localparam int         UTIC_BIT_PND_USB = 4;
    localparam int         UTIC_BIT_PND_T0  = 5;
    localparam int         UTIC_BIT_PND_T1  = 6;
    localparam int         UTIC_BIT_SUSPEND = 0;
    localparam int         UTIC_BIT_RESUME  = 3;
    localparam logic [7:0] UTIC_INTERRUPT_CONTROL_REG_RST    = 8'h00;
    localparam logic [7:0] UTIC_INTERRUPT_CONTROL_REG_MASK   = 8'h7F;
    localparam logic [7:0] UTIC_USC_MASK    = 8'h09;
    localparam logic [11:0] UTIC_VEC_USB    = 12'h004;
    localparam logic [11:0] UTIC_VEC_T0     = 12'h008;
    localparam logic [11:0] UTIC_VEC_T1     = 12'h00C;
    localparam int         UTIC_STACK_DEPTH = 8;
    localparam int         UTIC_PC_W        = 12;
    localparam int         UTIC_EP_NUM      = 3;
    typedef enum logic [1:0] {UTIC_SRC_USB, UTIC_SRC_T0, UTIC_SRC_T1, UTIC_SRC_NONE} utic_src_e;
endpackage

// ---- logic/utic_arbiter.sv ----
// Fixed-priority pick among enabled pending sources.
// Assumes pending and enable bits come straight from the control register.
`timescale 1ns/1ps
module utic_arbiter
    import utic_pkg::*;
(
    // Request inputs
    input  wire logic [2:0]              pend,
    input  wire logic [2:0]              en,
    input  wire logic                    gen,
    input  wire logic                    stack_full,
    // Selection
    output utic_pkg::utic_src_e          src,
    output logic [utic_pkg::UTIC_PC_W-1:0] vector
);
    logic [2:0] live;
    assign live = pend & en & {3{gen & ~stack_full}};
    always_comb
    begin
        src    = UTIC_SRC_NONE;
        vector = UTIC_VEC_USB;
        if (live[0])
        begin
            src    = UTIC_SRC_USB;
            vector = UTIC_VEC_USB;
        end
        else if (live[1])
        begin
            src    = UTIC_SRC_T0;
            vector = UTIC_VEC_T0;
        end
        else if (live[2])
        begin
            src    = UTIC_SRC_T1;
            vector = UTIC_VEC_T1;
        end
    end
endmodule

// ---- logic/utic_stack.sv ----
// Eight-entry return-address stack; entry pushes only the program counter.
// Assumes the core never pushes and pops in the same cycle.
`timescale 1ns/1ps
module utic_stack
    import utic_pkg::*;
#(
    parameter int DEPTH = utic_pkg::UTIC_STACK_DEPTH
)
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Push and pop
    input  wire logic                       push,
    input  wire logic [utic_pkg::UTIC_PC_W-1:0] push_pc,
    input  wire logic                       pop,
    output logic [utic_pkg::UTIC_PC_W-1:0]  top_pc,
    output logic [$clog2(DEPTH):0]          level,
    output logic                            full
);
    logic [UTIC_PC_W-1:0]    mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wp_r;
    logic [$clog2(DEPTH):0]   level_r;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_r] <= push_pc;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wp_r    <= '0;
            level_r <= '0;
        end
        else if (push)
        begin
            wp_r <= wp_r + 1'b1;           // Overflow drops oldest entry
            if (level_r != DEPTH[$clog2(DEPTH):0])
                level_r <= level_r + 1'b1;
        end
        else if (pop && level_r != '0)
        begin
            wp_r    <= wp_r - 1'b1;
            level_r <= level_r - 1'b1;
        end
    end

    assign top_pc = mem[wp_r - 1'b1];
    assign level  = level_r;
    assign full   = (level_r == DEPTH[$clog2(DEPTH):0]);
endmodule

// ---- logic/utic_controller.sv ----
// Interrupt controller top: control register, USB status registers,
// phase-two sampling, acknowledge towards the core sequencer.
// Assumes the core drives one-cycle data memory strobes synchronous to clk.
`timescale 1ns/1ps
module utic_controller
    import utic_pkg::*;
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         clock_phase_two,
    // Data memory access
    input  wire logic [7:0]                   mem_addr,
    input  wire logic                         mem_wr,
    input  wire logic                         mem_rd,
    input  wire logic [7:0]                   mem_wdata,
    output logic [7:0]                        mem_rdata,
    // Core sequencer
    input  wire logic [utic_pkg::UTIC_PC_W-1:0] core_pc,
    input  wire logic                         call_exec,
    input  wire logic                         ret_exec,
    input  wire logic                         irq_exit_reenable,
    input  wire logic                         core_halted,
    output logic                              irq_take,
    output logic [utic_pkg::UTIC_PC_W-1:0]    irq_vector,
    output logic [utic_pkg::UTIC_PC_W-1:0]    return_pc,
    output logic                              stack_full,
    output logic                              wake_req,
    // Event sources
    input  wire logic                         timer0_overflow,
    input  wire logic                         timer1_overflow,
    input  wire logic [utic_pkg::UTIC_EP_NUM-1:0] ep_fifo_access,
    input  wire logic                         usb_suspend,
    input  wire logic                         usb_resume,
    input  wire logic                         usb_bus_reset,
    // Register views
    output logic [7:0]                        interrupt_control_reg,
    output logic [7:0]                        usb_ctrl_status,
    output logic [utic_pkg::UTIC_EP_NUM-1:0]  endpoint_access_status
);
    import utic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and event gathering

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] t, input logic w);
        wr_hit = w && (a == t);
    endfunction

    logic       wr_interrupt_control_reg;
    logic       wr_usc;
    logic       wr_usr;
    logic [2:0] ev_set;
    logic [2:0] ev_raw_r;
    logic       usb_event;
    logic [7:0] interrupt_control_reg_r;
    logic [7:0] usc_r;
    logic [UTIC_EP_NUM-1:0] usr_r;
    logic       take_r;
    logic [UTIC_PC_W-1:0] vec_r;
    logic       wake_r;
    logic [7:0] rdata_r;
    logic       full_w;
    logic [UTIC_PC_W-1:0] top_w;
    utic_src_e  src_w;
    logic [UTIC_PC_W-1:0] vec_w;
    logic       take_now;
    logic [2:0] svc_clr;

    assign wr_interrupt_control_reg = wr_hit(mem_addr, UTIC_INTERRUPT_CONTROL_REG_ADDR, mem_wr);
    assign wr_usc  = wr_hit(mem_addr, UTIC_USC_ADDR, mem_wr);
    assign wr_usr  = wr_hit(mem_addr, UTIC_USR_ADDR, mem_wr);

    assign usb_event = (|ep_fifo_access) | usb_suspend | usb_resume
                     | usb_bus_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Events accumulate between phase-two pulses, then reach the flags

    always_ff @(posedge clk)
    begin
        if (reset)
            ev_raw_r <= 3'h0;
        else if (clock_phase_two)
            ev_raw_r <= {timer1_overflow, timer0_overflow, usb_event};
        else
            ev_raw_r <= ev_raw_r | {timer1_overflow, timer0_overflow, usb_event};
    end

    assign ev_set = clock_phase_two ? ev_raw_r : 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration and stack

    utic_arbiter u_arb (
        .pend       (interrupt_control_reg_r[UTIC_BIT_PND_T1:UTIC_BIT_PND_USB]),
        .en         (interrupt_control_reg_r[UTIC_BIT_EN_T1:UTIC_BIT_EN_USB]),
        .gen        (interrupt_control_reg_r[UTIC_BIT_GEN]),
        .stack_full (full_w),
        .src        (src_w),
        .vector     (vec_w)
    );

    utic_stack u_stack (
        .clk     (clk),
        .reset   (reset),
        .push    (call_exec | take_r),
        .push_pc (core_pc),
        .pop     (ret_exec | irq_exit_reenable),
        .top_pc  (top_w),
        .level   (),
        .full    (full_w)
    );

    // Service on phase two only; not while the previous entry is in flight
    assign take_now = clock_phase_two && !take_r && (src_w != UTIC_SRC_NONE);

    always_comb
    begin
        svc_clr = 3'h0;
        if (take_now)
        begin
            case (src_w)
                UTIC_SRC_USB: svc_clr = 3'h1;
                UTIC_SRC_T0:  svc_clr = 3'h2;
                UTIC_SRC_T1:  svc_clr = 3'h4;
                default:      svc_clr = 3'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt control register

    always_ff @(posedge clk)
    begin
        if (reset)
            interrupt_control_reg_r <= UTIC_INTERRUPT_CONTROL_REG_RST;
        else
        begin
            // Global enable: software write, cleared on entry, set by interrupt return; source enables: write only
            if (take_now)
                interrupt_control_reg_r[UTIC_BIT_GEN] <= 1'b0;
            else if (irq_exit_reenable)
                interrupt_control_reg_r[UTIC_BIT_GEN] <= 1'b1;
            else if (wr_interrupt_control_reg)
                interrupt_control_reg_r[UTIC_BIT_GEN] <= mem_wdata[UTIC_BIT_GEN];
            if (wr_interrupt_control_reg)
                interrupt_control_reg_r[UTIC_BIT_EN_T1:UTIC_BIT_EN_USB] <=
                    mem_wdata[UTIC_BIT_EN_T1:UTIC_BIT_EN_USB];
            // Pending: set beats clear by service or write
            interrupt_control_reg_r[UTIC_BIT_PND_T1:UTIC_BIT_PND_USB] <= ev_set |
                ((wr_interrupt_control_reg ? mem_wdata[UTIC_BIT_PND_T1:UTIC_BIT_PND_USB]
                          : interrupt_control_reg_r[UTIC_BIT_PND_T1:UTIC_BIT_PND_USB]) & ~svc_clr);
            interrupt_control_reg_r[7] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // USB status and endpoint access status

    always_ff @(posedge clk)
    begin
        if (reset)
            usc_r <= 8'h00;
        else
        begin
            usc_r <= (wr_usc ? (mem_wdata & UTIC_USC_MASK) : usc_r);
            if (usb_suspend)
                usc_r[UTIC_BIT_SUSPEND] <= 1'b1;
            if (usb_resume)
                usc_r[UTIC_BIT_RESUME] <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            usr_r <= '0;
        else
            usr_r <= ep_fifo_access |
                     (wr_usr ? mem_wdata[UTIC_EP_NUM-1:0] : usr_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs towards the core

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            take_r <= 1'b0;
            vec_r  <= UTIC_VEC_USB;
        end
        else
        begin
            take_r <= take_now;
            if (take_now)
                vec_r <= vec_w;
        end
    end

    // Any raised request wakes a halted core; flags set before halt do not
    always_ff @(posedge clk)
    begin
        if (reset)
            wake_r <= 1'b0;
        else
            wake_r <= core_halted && (|ev_set);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_r <= 8'h00;
        else if (mem_rd)
        begin
            case (mem_addr)
                UTIC_INTERRUPT_CONTROL_REG_ADDR: rdata_r <= interrupt_control_reg_r & UTIC_INTERRUPT_CONTROL_REG_MASK;
                UTIC_USC_ADDR:  rdata_r <= usc_r;
                UTIC_USR_ADDR:  rdata_r <= {{(8-UTIC_EP_NUM){1'b0}}, usr_r};
                default:        rdata_r <= 8'h00;
            endcase
        end
    end

    assign irq_take               = take_r;
    assign irq_vector             = vec_r;
    assign return_pc              = top_w;
    assign stack_full             = full_w;
    assign wake_req               = wake_r;
    assign mem_rdata              = rdata_r;
    assign interrupt_control_reg  = interrupt_control_reg_r;
    assign usb_ctrl_status        = usc_r;
    assign endpoint_access_status = usr_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    gen_gate_a: assert property (take_now |-> interrupt_control_reg_r[UTIC_BIT_GEN])
        else $error("interrupt taken with global enable low");
    entry_clears_gen_a: assert property (take_now |=> !interrupt_control_reg_r[UTIC_BIT_GEN])
        else $error("global enable not cleared on entry");
    full_blocks_a: assert property (full_w |-> !take_now)
        else $error("acknowledge while stack full");
    bit7_zero_a: assert property (interrupt_control_reg_r[7] == 1'b0)
        else $error("bit 7 not zero");
    usb_vec_a: assert property (take_now && src_w == UTIC_SRC_USB && !ev_set[0]
        |=> irq_take && irq_vector == UTIC_VEC_USB && !interrupt_control_reg_r[UTIC_BIT_PND_USB])
        else $error("usb vector or flag wrong");
    prio_t1_a: assert property (take_now && src_w == UTIC_SRC_T1
        |-> !(interrupt_control_reg_r[UTIC_BIT_PND_USB] && interrupt_control_reg_r[UTIC_BIT_EN_USB]))
        else $error("timer1 taken over usb");
    set_wins_a: assert property (ev_set[1] |=> interrupt_control_reg_r[UTIC_BIT_PND_T0])
        else $error("timer0 request lost");
    irq_exit_reenable_sets_a: assert property (irq_exit_reenable && !take_now
        |=> interrupt_control_reg_r[UTIC_BIT_GEN])
        else $error("return did not re-enable");
    phase_only_a: assert property (take_now |-> clock_phase_two)
        else $error("service off phase two");
    suspend_flag_a: assert property (usb_suspend |=> usc_r[UTIC_BIT_SUSPEND])
        else $error("suspend bit not set");

    usb_take_c:  cover property (take_now && src_w == UTIC_SRC_USB);
    t1_take_c:   cover property (take_now && src_w == UTIC_SRC_T1);
    full_hold_c: cover property (full_w && interrupt_control_reg_r[UTIC_BIT_GEN] && |interrupt_control_reg_r[6:4]);
    nest_c:      cover property (take_r ##[1:20] take_r);
endmodule

// ---- verification/utic_core_model.sv ----
// Behavioural model of the core sequencer that faces the interrupt controller.
// Assumes one instruction phase every four clocks and a program counter that
// steps by one each clock until an acknowledge redirects it to the vector.
`timescale 1ns/1ps
module utic_core_model
    import utic_pkg::*;
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // Acknowledge from the controller
    input  wire logic                          irq_take,
    input  wire logic [utic_pkg::UTIC_PC_W-1:0] irq_vector,
    // Sequencer outputs
    output logic                               clock_phase_two,
    output logic [utic_pkg::UTIC_PC_W-1:0]     core_pc
);
    logic [1:0] phase_r;

    ////////////////////////////////////////////////////////////////////////////
    // Four-clock instruction phase, second-phase strobe once per instruction
    always_ff @(posedge clk)
    begin
        if (reset)
            phase_r <= 2'h0;
        else
            phase_r <= phase_r + 2'h1;
    end
    assign clock_phase_two = (phase_r == 2'h3);

    ////////////////////////////////////////////////////////////////////////////
    // Program counter: only this value is offered for the push on entry
    always_ff @(posedge clk)
    begin
        if (reset)
            core_pc <= 12'h000;
        else if (irq_take)
            core_pc <= irq_vector;
        else
            core_pc <= core_pc + 12'h001;
    end
endmodule

// ---- verification/utic_controller_bench.sv ----
// Self-checking bench for the interrupt controller with a core sequencer model.
// Assumes inputs change 1 ns after each rising edge of a 250 MHz clock.
`timescale 1ns/1ps
module utic_controller_bench;
    import utic_pkg::*;
    logic        clk, reset, clock_phase_two, mem_wr, mem_rd, call_exec, ret_exec;
    logic        irq_exit_reenable, core_halted, irq_take, stack_full, wake_req;
    logic        timer0_overflow, timer1_overflow, usb_suspend, usb_resume, usb_bus_reset;
    logic [7:0]  mem_addr, mem_wdata, mem_rdata, interrupt_control_reg, usb_ctrl_status;
    logic [11:0] core_pc, irq_vector, return_pc, vec, pc;
    logic [2:0]  ep_fifo_access, endpoint_access_status, ep;
    logic [7:0]  d, v;
    int          miscompares, checked, seed;

    utic_controller i_utic_controller (.clk(clk), .reset(reset),
        .clock_phase_two(clock_phase_two), .mem_addr(mem_addr), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .core_pc(core_pc),
        .call_exec(call_exec), .ret_exec(ret_exec), .irq_exit_reenable(irq_exit_reenable),
        .core_halted(core_halted), .irq_take(irq_take), .irq_vector(irq_vector),
        .return_pc(return_pc), .stack_full(stack_full), .wake_req(wake_req),
        .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
        .ep_fifo_access(ep_fifo_access), .usb_suspend(usb_suspend), .usb_resume(usb_resume),
        .usb_bus_reset(usb_bus_reset), .interrupt_control_reg(interrupt_control_reg),
        .usb_ctrl_status(usb_ctrl_status), .endpoint_access_status(endpoint_access_status));

    utic_core_model i_utic_core_model (.clk(clk), .reset(reset), .irq_take(irq_take),
        .irq_vector(irq_vector), .clock_phase_two(clock_phase_two), .core_pc(core_pc));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        reset = 1'b1;
        cyc(10);
        reset = 1'b0;
        cyc(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        mem_addr  = a;
        mem_wdata = w;
        mem_wr    = 1'b1;
        cyc(1);
        mem_wr    = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        mem_addr = a;
        mem_rd   = 1'b1;
        cyc(1);
        mem_rd   = 1'b0;
        r        = mem_rdata;
    endtask

    // Event pulse: {bus reset, resume, suspend, timer1, timer0}, then a phase passes
    task automatic ev(input logic [4:0] m, input logic [2:0] e);
        {usb_bus_reset, usb_resume, usb_suspend, timer1_overflow, timer0_overflow} = m;
        ep_fifo_access = e;
        cyc(1);
        {usb_bus_reset, usb_resume, usb_suspend, timer1_overflow, timer0_overflow} = 5'h00;
        ep_fifo_access = 3'h0;
        cyc(6);
    endtask

    // Core strobe: {return with re-enable, plain return, call}
    task automatic core(input logic [2:0] m);
        {irq_exit_reenable, ret_exec, call_exec} = m;
        cyc(1);
        {irq_exit_reenable, ret_exec, call_exec} = 3'h0;
        cyc(1);
    endtask

    // Bounded wait for acknowledge (0) or wake request (1)
    task automatic wait_hi(input int which);
        int i;
        for (i = 0; i < 40; i++)
        begin
            if ((which == 0 && irq_take === 1'b1) || (which == 1 && wake_req === 1'b1))
            begin
                vec = irq_vector;
                pc  = core_pc;
                return;
            end
            cyc(1);
        end
        miscompares++;
        $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        test_done();
    endtask

    task automatic no_take(input int n);
        repeat (n)
        begin
            chk(irq_take, 1'b0);
            cyc(1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {mem_wr, mem_rd, call_exec, ret_exec, irq_exit_reenable, core_halted} = 6'h00;
        {usb_bus_reset, usb_resume, usb_suspend, timer1_overflow, timer0_overflow} = 5'h00;
        {mem_addr, mem_wdata, ep_fifo_access} = 19'h00000;
        miscompares = 0;
        checked     = 0;
        seed        = $urandom(20615);
        do_reset();
        rd(UTIC_INTERRUPT_CONTROL_REG_ADDR, d);
        chk(d, UTIC_INTERRUPT_CONTROL_REG_RST);
        repeat (6)
        begin
            v = 8'($urandom) & 8'h8E;
            wr(UTIC_INTERRUPT_CONTROL_REG_ADDR, v);
            rd(UTIC_INTERRUPT_CONTROL_REG_ADDR, d);
            chk(d, v & UTIC_INTERRUPT_CONTROL_REG_MASK);
        end
        rd(8'h30, d);
        chk(d, 8'h00);
        // Three sources pending with the global enable off, then priority order
        wr(UTIC_INTERRUPT_CONTROL_REG_ADDR, 8'h0E);
        ev(5'h07, 3'h0);
        no_take(12);
        rd(UTIC_INTERRUPT_CONTROL_REG_ADDR, d);
        chk(d, 8'h7E);
        chk(usb_ctrl_status, 8'h01);
        wr(UTIC_INTERRUPT_CONTROL_REG_ADDR, 8'h7F);
        wait_hi(0);
        chk(vec, UTIC_VEC_USB);
        cyc(1);
        chk(return_pc, pc);
        rd(UTIC_INTERRUPT_CONTROL_REG_ADDR, d);
        chk(d, 8'h6E);
        wr(UTIC_INTERRUPT_CONTROL_REG_ADDR, 8'h6F);
        wait_hi(0);
        chk(vec, UTIC_VEC_T0);
        core(3'h4);
        wait_hi(0);
        chk(vec, UTIC_VEC_T1);
        // Full stack withholds service until one return
        do_reset();
        repeat (UTIC_STACK_DEPTH) core(3'h1);
        chk(stack_full, 1'b1);
        wr(UTIC_INTERRUPT_CONTROL_REG_ADDR, 8'h05);
        ev(5'h01, 3'h0);
        no_take(12);
        core(3'h2);
        wait_hi(0);
        chk(vec, UTIC_VEC_T0);
        cyc(1);
        core(3'h2);
        rd(UTIC_INTERRUPT_CONTROL_REG_ADDR, d);
        chk(d, 8'h04);
        chk(interrupt_control_reg, 8'h04);
        // USB status events
        do_reset();
        ep = 3'h1 << ($urandom % 3);
        ev(5'h08, ep);
        chk(endpoint_access_status, ep);
        chk(usb_ctrl_status, 8'h08);
        rd(UTIC_INTERRUPT_CONTROL_REG_ADDR, d);
        chk(d, 8'h10);
        wr(UTIC_INTERRUPT_CONTROL_REG_ADDR, 8'h00);
        ev(5'h10, 3'h0);
        rd(UTIC_INTERRUPT_CONTROL_REG_ADDR, d);
        chk(d, 8'h10);
        // Wake from power-down
        do_reset();
        core_halted = 1'b1;
        // Wake stands one cycle only, so watch for it straight after the pulse
        timer1_overflow = 1'b1;
        cyc(1);
        timer1_overflow = 1'b0;
        wait_hi(1);
        chk(wake_req, 1'b1);
        core_halted = 1'b0;
        test_done();
    end
endmodule
